// file: verilog/pdicfg_defs.svh
// Offsets, field positions, mode codes and defaults of the config registers
`ifndef PDICFG_DEFS_SVH
`define PDICFG_DEFS_SVH
// Register offsets
`define PDICFG_OFS_IFACE 16'h0150
`define PDICFG_OFS_PULSE 16'h0151
`define PDICFG_OFS_EXT_LO 16'h0152
`define PDICFG_OFS_EXT_HI 16'h0153
// Mode select codes
`define PDICFG_SEL_DIO 8'h04
`define PDICFG_SEL_ASPI 8'h05
`define PDICFG_SEL_SPI_A 8'h80
`define PDICFG_SEL_SPI_B 8'h82
`define PDICFG_SEL_BUS_LO 8'h88
`define PDICFG_SEL_BUS_HI 8'h97
// Reset value
`define PDICFG_RST8 8'h00
`define PDICFG_RST16 16'h0000
// Readable-bit masks per mode
`define PDICFG_MSK_DIO 8'hff
`define PDICFG_MSK_SPI 8'h07
`define PDICFG_MSK_ASPI 8'h33
`define PDICFG_MSK_BUS 8'hff
`define PDICFG_MSK_EXT_BUS 16'h0007
// Interface config bit positions
`define PDICFG_B_OVPOL 0
`define PDICFG_B_BIDIR 2
`define PDICFG_B_SEVT 2
`define PDICFG_B_ACKPOL 1
`define PDICFG_B_ACKOD 0
`define PDICFG_B_LATE 5
`define PDICFG_B_SCSPOL 4
`define PDICFG_B_ALEQ 7
`define PDICFG_B_DIREN 6
`define PDICFG_B_CSPOL 5
`define PDICFG_B_RDPOL 4
`define PDICFG_B_WRPOL 3
`define PDICFG_B_ALEPOL 2
// Pulse/latch config bit positions
`define PDICFG_B_MAP1 7
`define PDICFG_B_FN1 6
`define PDICFG_B_DRV1 5:4
`define PDICFG_B_MAP0 3
`define PDICFG_B_FN0 2
`define PDICFG_B_DRV0 1:0
// Event request bit positions for the pulse mirror
`define PDICFG_EV_P1 3
`define PDICFG_EV_P0 2
`endif

// file: verilog/pdicfg_pkg.sv
// Types shared by the interface configuration block
package pdicfg_pkg;
  // Decoded interface mode, one-hot
  typedef enum logic [4:0] {
    PDICFG_M_NONE = 5'b00001,
    PDICFG_M_DIO = 5'b00010,
    PDICFG_M_SPI = 5'b00100,
    PDICFG_M_ASPI = 5'b01000,
    PDICFG_M_BUS = 5'b10000
  } pdicfg_mode_e;
endpackage

// file: verilog/pdicfg_drv.sv
// Decoder of a two-bit pulse driver code into pin level and enable
`timescale 1ns/10ps
`include "pdicfg_defs.svh"
module pdicfg_drv (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Configuration
  input wire logic [1:0] drv_code,
  input wire logic is_output,
  // Pulse state, active high internally
  input wire logic pulse,
  // Pin drive
  output logic pin_out,
  output logic pin_oe
);
  // Active level and whether the idle level is driven
  logic act_high;
  logic drive_idle;
  assign act_high = drv_code[1];
  // Push-pull codes drive both levels
  assign drive_idle = ~drv_code[0];

  // Registered pin level
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin_out <= 1'b0;
    end else begin
      pin_out <= pulse ? act_high : ~act_high;
    end
  end

  // Enable only as pulse output; open types release idle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin_oe <= 1'b0;
    end else begin
      pin_oe <= is_output & (pulse | drive_idle);
    end
  end
endmodule

// file: verilog/pdicfg_top.sv
// Interface configuration registers and their decoded control outputs
`timescale 1ns/10ps
`include "pdicfg_defs.svh"
module pdicfg_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // EEPROM load port
  input wire logic ld_valid,
  input wire logic [7:0] ld_iface,
  input wire logic [7:0] ld_pulse,
  input wire logic [15:0] ld_ext,
  input wire logic [7:0] interface_mode_select,
  // Read port, shared by network side and host side
  input wire logic rd_en,
  input wire logic [15:0] rd_addr,
  output logic [7:0] rd_data,
  output logic rd_hit,
  // Pulse sources from the clock unit
  input wire logic first_pulse_output,
  input wire logic second_pulse_output,
  // Pulse mirror into the event request
  output logic [3:2] application_layer_event,
  // Pulse/latch pins
  output logic pulse0_out,
  output logic pulse0_oe,
  output logic pulse1_out,
  output logic pulse1_oe,
  output logic first_latch_input_is_input,
  output logic second_latch_input_is_input,
  // Digital I/O mode controls
  output logic output_valid_active_low,
  output logic [15:0] dio_pair_out,
  // Serial host mode controls
  output logic serial_event_fwd_en,
  output logic [7:0] spi_pair_out,
  output logic [7:0] spi_pair_od,
  // Alternate serial mode controls
  output logic serial_late_sample,
  output logic serial_chip_select_high,
  output logic [1:0] serial_clock_mode,
  // Parallel bus controls
  output logic bus_ale_qualify,
  output logic bus_dir_enable,
  output logic bus_cs_high,
  output logic bus_rd_sense,
  output logic bus_wr_sense,
  output logic bus_ale_high,
  // Wait/acknowledge output shape, serial host or parallel bus
  output logic ack_active_high,
  output logic ack_open_drain
);
  // Stored registers and mode
  logic [7:0] iface_config_q;
  logic [7:0] pulse_latch_config_q;
  logic [15:0] extended_iface_config_q;
  logic [7:0] mode_sel_q;
  pdicfg_pkg::pdicfg_mode_e mode_q;
  pdicfg_pkg::pdicfg_mode_e mode_d;
  // Synchronised pulses
  logic [1:0] p0_sync_q;
  logic [1:0] p1_sync_q;
  // Masks for the current mode
  logic [7:0] msk_if;
  logic [15:0] msk_ext;
  logic [7:0] rd_d;
  logic hit_d;
  logic [15:0] dio_dir;

  // Mode decode from the select code
  always_comb begin
    mode_d = pdicfg_pkg::PDICFG_M_NONE;
    if (mode_sel_q == `PDICFG_SEL_DIO) begin
      mode_d = pdicfg_pkg::PDICFG_M_DIO;
    end else if (mode_sel_q == `PDICFG_SEL_ASPI) begin
      mode_d = pdicfg_pkg::PDICFG_M_ASPI;
    end else if (mode_sel_q == `PDICFG_SEL_SPI_A ||
                 mode_sel_q == `PDICFG_SEL_SPI_B) begin
      mode_d = pdicfg_pkg::PDICFG_M_SPI;
    end else if (mode_sel_q >= `PDICFG_SEL_BUS_LO &&
                 mode_sel_q <= `PDICFG_SEL_BUS_HI) begin
      mode_d = pdicfg_pkg::PDICFG_M_BUS;
    end
  end

  // Masks keep reserved positions at zero
  always_comb begin
    msk_if = `PDICFG_RST8;
    msk_ext = `PDICFG_RST16;
    case (mode_d)
      pdicfg_pkg::PDICFG_M_DIO: begin
        msk_if = `PDICFG_MSK_DIO;
        msk_ext = ~`PDICFG_RST16;
      end
      pdicfg_pkg::PDICFG_M_SPI: begin
        msk_if = `PDICFG_MSK_SPI;
        msk_ext = ~`PDICFG_RST16;
      end
      pdicfg_pkg::PDICFG_M_ASPI: begin
        msk_if = `PDICFG_MSK_ASPI;
      end
      pdicfg_pkg::PDICFG_M_BUS: begin
        msk_if = `PDICFG_MSK_BUS;
        msk_ext = `PDICFG_MSK_EXT_BUS;
      end
      default: begin
        msk_if = `PDICFG_RST8;
      end
    endcase
  end

  // Mode select capture at load time
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mode_sel_q <= `PDICFG_RST8;
    end else if (ld_valid) begin
      mode_sel_q <= interface_mode_select;
    end
  end

  // Decoded mode register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mode_q <= pdicfg_pkg::PDICFG_M_NONE;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Load from EEPROM only; no write path exists
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      iface_config_q <= `PDICFG_RST8;
      pulse_latch_config_q <= `PDICFG_RST8;
      extended_iface_config_q <= `PDICFG_RST16;
    end else if (ld_valid) begin
      iface_config_q <= ld_iface;
      pulse_latch_config_q <= ld_pulse;
      extended_iface_config_q <= ld_ext;
    end
  end

  // Read mux, reserved bits masked to zero
  always_comb begin
    rd_d = `PDICFG_RST8;
    hit_d = 1'b1;
    if (rd_addr == `PDICFG_OFS_IFACE) begin
      rd_d = iface_config_q & msk_if;
    end else if (rd_addr == `PDICFG_OFS_PULSE) begin
      rd_d = pulse_latch_config_q;
    end else if (rd_addr == `PDICFG_OFS_EXT_LO) begin
      rd_d = extended_iface_config_q[7:0] & msk_ext[7:0];
    end else if (rd_addr == `PDICFG_OFS_EXT_HI) begin
      rd_d = extended_iface_config_q[15:8] & msk_ext[15:8];
    end else begin
      hit_d = 1'b0;
    end
  end

  // Registered read answer, one cycle after the request
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_data <= `PDICFG_RST8;
      rd_hit <= 1'b0;
    end else if (rd_en) begin
      rd_data <= rd_d;
      rd_hit <= hit_d;
    end else begin
      rd_data <= `PDICFG_RST8;
      rd_hit <= 1'b0;
    end
  end

  // Two-stage synchronisers for the pulse sources
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      p0_sync_q <= 2'b00;
      p1_sync_q <= 2'b00;
    end else begin
      p0_sync_q <= {p0_sync_q[0], first_pulse_output};
      p1_sync_q <= {p1_sync_q[0], second_pulse_output};
    end
  end

  // Pulse mirror into the event request
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      application_layer_event <= 2'b00;
    end else begin
      application_layer_event[`PDICFG_EV_P1] <= p1_sync_q[1] &
        pulse_latch_config_q[`PDICFG_B_MAP1];
      application_layer_event[`PDICFG_EV_P0] <= p0_sync_q[1] &
        pulse_latch_config_q[`PDICFG_B_MAP0];
    end
  end

  // Pin functions: latch input when the function bit is clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      first_latch_input_is_input <= 1'b1;
      second_latch_input_is_input <= 1'b1;
    end else begin
      first_latch_input_is_input <= ~pulse_latch_config_q[`PDICFG_B_FN0];
      second_latch_input_is_input <= ~pulse_latch_config_q[`PDICFG_B_FN1];
    end
  end

  // First pulse pin driver
  pdicfg_drv u_drv0 (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .drv_code(pulse_latch_config_q[`PDICFG_B_DRV0]),
    .is_output(pulse_latch_config_q[`PDICFG_B_FN0]),
    .pulse(p0_sync_q[1]),
    .pin_out(pulse0_out),
    .pin_oe(pulse0_oe)
  );

  // Second pulse pin driver
  pdicfg_drv u_drv1 (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .drv_code(pulse_latch_config_q[`PDICFG_B_DRV1]),
    .is_output(pulse_latch_config_q[`PDICFG_B_FN1]),
    .pulse(p1_sync_q[1]),
    .pin_out(pulse1_out),
    .pin_oe(pulse1_oe)
  );

  // Directions forced to input in bidirectional mode; loader should
  // already hold them at zero
  assign dio_dir = iface_config_q[`PDICFG_B_BIDIR] ? `PDICFG_RST16 :
                   extended_iface_config_q;

  // Digital I/O mode controls
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      output_valid_active_low <= 1'b0;
      dio_pair_out <= `PDICFG_RST16;
    end else if (mode_q == pdicfg_pkg::PDICFG_M_DIO) begin
      output_valid_active_low <= iface_config_q[`PDICFG_B_OVPOL];
      dio_pair_out <= dio_dir;
    end else begin
      output_valid_active_low <= 1'b0;
      dio_pair_out <= `PDICFG_RST16;
    end
  end

  // Serial host mode controls
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      serial_event_fwd_en <= 1'b0;
      spi_pair_od <= `PDICFG_RST8;
      spi_pair_out <= `PDICFG_RST8;
    end else if (mode_q == pdicfg_pkg::PDICFG_M_SPI) begin
      serial_event_fwd_en <= iface_config_q[`PDICFG_B_SEVT];
      spi_pair_od <= extended_iface_config_q[15:8];
      spi_pair_out <= extended_iface_config_q[7:0];
    end else begin
      serial_event_fwd_en <= 1'b0;
      spi_pair_od <= `PDICFG_RST8;
      spi_pair_out <= `PDICFG_RST8;
    end
  end

  // Alternate serial mode controls
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      serial_late_sample <= 1'b0;
      serial_chip_select_high <= 1'b0;
      serial_clock_mode <= 2'b00;
    end else if (mode_q == pdicfg_pkg::PDICFG_M_ASPI) begin
      serial_late_sample <= iface_config_q[`PDICFG_B_LATE];
      serial_chip_select_high <= iface_config_q[`PDICFG_B_SCSPOL];
      serial_clock_mode <= iface_config_q[1:0];
    end else begin
      serial_late_sample <= 1'b0;
      serial_chip_select_high <= 1'b0;
      serial_clock_mode <= 2'b00;
    end
  end

  // Parallel bus controls
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bus_ale_qualify <= 1'b0;
      bus_dir_enable <= 1'b0;
      bus_cs_high <= 1'b0;
      bus_rd_sense <= 1'b0;
      bus_wr_sense <= 1'b0;
      bus_ale_high <= 1'b0;
    end else if (mode_q == pdicfg_pkg::PDICFG_M_BUS) begin
      bus_ale_qualify <= iface_config_q[`PDICFG_B_ALEQ];
      bus_dir_enable <= iface_config_q[`PDICFG_B_DIREN];
      bus_cs_high <= iface_config_q[`PDICFG_B_CSPOL];
      bus_rd_sense <= iface_config_q[`PDICFG_B_RDPOL];
      bus_wr_sense <= iface_config_q[`PDICFG_B_WRPOL];
      bus_ale_high <= iface_config_q[`PDICFG_B_ALEPOL];
    end else begin
      bus_ale_qualify <= 1'b0;
      bus_dir_enable <= 1'b0;
      bus_cs_high <= 1'b0;
      bus_rd_sense <= 1'b0;
      bus_wr_sense <= 1'b0;
      bus_ale_high <= 1'b0;
    end
  end

  // Acknowledge shape for serial host or parallel bus
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ack_active_high <= 1'b0;
      ack_open_drain <= 1'b0;
    end else if (mode_q == pdicfg_pkg::PDICFG_M_SPI ||
                 mode_q == pdicfg_pkg::PDICFG_M_BUS) begin
      ack_active_high <= iface_config_q[`PDICFG_B_ACKPOL];
      ack_open_drain <= iface_config_q[`PDICFG_B_ACKOD];
    end else begin
      ack_active_high <= 1'b0;
      ack_open_drain <= 1'b0;
    end
  end
endmodule

// file: verif/pdicfg_top_asserts.sv
// Checker of the configuration block ports, with its bind
`timescale 1ns/10ps
module pdicfg_top_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Load and read
  input wire logic ld_valid,
  input wire logic [7:0] ld_iface,
  input wire logic [7:0] ld_pulse,
  input wire logic [7:0] interface_mode_select,
  input wire logic rd_en,
  input wire logic [15:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic rd_hit,
  // Pulses and decoded controls
  input wire logic first_pulse_output,
  input wire logic [3:2] application_layer_event,
  input wire logic first_latch_input_is_input,
  input wire logic second_latch_input_is_input,
  input wire logic [1:0] serial_clock_mode,
  input wire logic bus_ale_qualify,
  input wire logic ack_active_high
);
  logic [7:0] ifc_q; // Shadow of loaded interface config
  logic [7:0] pls_q; // Shadow of loaded pulse config
  logic [7:0] sel_q; // Shadow of loaded mode select
  logic bus_m; // Shadow mode is a parallel bus mode
  logic spi_m; // Shadow mode is serial host
  // Shadow follows each load
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ifc_q <= 8'h00;
      pls_q <= 8'h00;
      sel_q <= 8'h00;
    end else if (ld_valid) begin
      ifc_q <= ld_iface;
      pls_q <= ld_pulse;
      sel_q <= interface_mode_select;
    end
  end
  assign bus_m = sel_q >= 8'h88 && sel_q <= 8'h97;
  assign spi_m = sel_q == 8'h80 || sel_q == 8'h82;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // No load for four cycles, so every decoded output has settled
  sequence quiet4;
    !ld_valid [*4];
  endsequence
  // First pulse steady long enough to cross the synchroniser
  sequence steady0;
    (!ld_valid && $stable(first_pulse_output)) [*4];
  endsequence
  read_hit_a: assert property (
    rd_en && rd_addr[15:2] == 14'h0054 |=> rd_hit)
    else $error("mapped read not acknowledged");
  read_miss_a: assert property (
    !(rd_en && rd_addr[15:2] == 14'h0054) ##1 1 |->
    !rd_hit && rd_data == 8'h00)
    else $error("idle or unmapped read not zero");
  iface_mask_a: assert property (
    !ld_valid && rd_en && rd_addr == 16'h0150
    && (spi_m || sel_q == 8'h05) |=>
    rd_data == (ifc_q & (spi_m ? 8'h07 : 8'h33)))
    else $error("reserved bits not masked");
  latch_fn_a: assert property (
    quiet4 |-> first_latch_input_is_input == !pls_q[2] &&
    second_latch_input_is_input == !pls_q[6])
    else $error("latch pin function wrong");
  event_map_a: assert property (
    steady0 |-> application_layer_event[2] ==
    (first_pulse_output && pls_q[3]))
    else $error("pulse mirror wrong");
  clock_mode_a: assert property (
    quiet4 |-> serial_clock_mode ==
    (sel_q == 8'h05 ? ifc_q[1:0] : 2'b00))
    else $error("serial clock mode wrong");
  bus_qual_a: assert property (
    quiet4 |-> bus_ale_qualify == (bus_m && ifc_q[7]))
    else $error("address qualify wrong");
  ack_pol_a: assert property (
    quiet4 |-> ack_active_high == ((bus_m || spi_m) && ifc_q[1]))
    else $error("acknowledge polarity wrong");
endmodule
bind pdicfg_top pdicfg_top_asserts i_chk (.mclk, .sys_rst, .ld_valid,
  .ld_iface, .ld_pulse, .interface_mode_select, .rd_en, .rd_addr, .rd_data,
  .rd_hit,
  .first_pulse_output, .application_layer_event, .first_latch_input_is_input,
  .second_latch_input_is_input, .serial_clock_mode, .bus_ale_qualify, .ack_active_high);

// file: verif/pdicfg_eeprom_model.sv
// Configuration image source that loads the block after a delay
`timescale 1ns/10ps
module pdicfg_eeprom_model (
  // Clock and request
  input wire logic mclk,
  input wire logic go,
  input wire logic [3:0] delay,
  // Image to load
  input wire logic [7:0] img_sel,
  input wire logic [7:0] img_iface,
  input wire logic [7:0] img_pulse,
  input wire logic [15:0] img_ext,
  // Load port
  output logic ld_valid,
  output logic [7:0] ld_iface,
  output logic [7:0] ld_pulse,
  output logic [15:0] ld_ext,
  output logic [7:0] interface_mode_select
);
  // Idle until asked, wait, then one load cycle
  initial begin
    ld_valid = 1'b0;
    {ld_iface, ld_pulse, ld_ext, interface_mode_select} = 40'h0;
    forever begin
      @(posedge mclk);
      if (go) begin
        repeat (delay) @(posedge mclk);
        #1;
        ld_valid = 1'b1;
        ld_iface = img_iface;
        ld_pulse = img_pulse;
        interface_mode_select = img_sel;
        // Bidirectional I/O image carries no directions
        ld_ext = (img_sel == 8'h04 && img_iface[2]) ? 16'h0 : img_ext;
        @(posedge mclk);
        #1;
        ld_valid = 1'b0;
        // Lines not held after the load show garbage
        {ld_iface, ld_pulse, ld_ext} = ~{ld_iface, ld_pulse, ld_ext};
        interface_mode_select = ~interface_mode_select;
      end
    end
  end
endmodule

// file: verif/tb.sv
// Bench for the interface configuration block
`timescale 1ns/10ps
module tb;
  logic mclk, sys_rst, go, rd_en, rd_hit, ld_valid; // Control lines
  logic first_pulse_output, second_pulse_output; // Pulse sources
  logic [3:0] delay; // Loader latency
  logic [7:0] img_sel, img_iface, img_pulse, rd_data, ld_iface, ld_pulse;
  logic [7:0] interface_mode_select, spi_pair_out, spi_pair_od;
  logic [15:0] img_ext, rd_addr, ld_ext, dio_pair_out;
  logic [3:2] application_layer_event; // Pulse mirror
  logic [1:0] serial_clock_mode; // Alternate serial clock mode
  logic pulse0_out, pulse0_oe, pulse1_out, pulse1_oe, first_latch_input_is_input;
  logic second_latch_input_is_input, output_valid_active_low, serial_event_fwd_en;
  logic serial_late_sample, serial_chip_select_high, bus_ale_qualify;
  logic bus_dir_enable, bus_cs_high, bus_rd_sense, bus_wr_sense;
  logic bus_ale_high, ack_active_high, ack_open_drain;
  int miscompares = 0; // Mismatches seen
  int num_checks = 0; // Comparisons made
  int cyc = 0; // Cycle count for the hang limit
  pdicfg_eeprom_model i_src (.mclk, .go, .delay, .img_sel, .img_iface,
    .img_pulse, .img_ext, .ld_valid, .ld_iface, .ld_pulse, .ld_ext,
    .interface_mode_select);
  pdicfg_top i_dut (.mclk, .sys_rst, .ld_valid, .ld_iface, .ld_pulse, .ld_ext,
    .interface_mode_select, .rd_en, .rd_addr, .rd_data, .rd_hit,
    .first_pulse_output, .second_pulse_output, .application_layer_event,
    .pulse0_out, .pulse0_oe, .pulse1_out, .pulse1_oe, .first_latch_input_is_input,
    .second_latch_input_is_input, .output_valid_active_low, .dio_pair_out,
    .serial_event_fwd_en, .spi_pair_out, .spi_pair_od, .serial_late_sample,
    .serial_chip_select_high, .serial_clock_mode, .bus_ale_qualify,
    .bus_dir_enable, .bus_cs_high, .bus_rd_sense, .bus_wr_sense, .bus_ale_high,
    .ack_active_high, .ack_open_drain);
  // Verdict and end of run
  task automatic close_out();
    if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Compare seen against expected
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Ask the loader for an image and let the outputs settle
  task automatic load(input logic [7:0] s, i, p, input logic [15:0] e,
    input logic [3:0] d);
    {img_sel, img_iface, img_pulse, img_ext, delay} = {s, i, p, e, d};
    go = 1'b1;
    @(posedge mclk);
    #1;
    go = 1'b0;
    repeat (d + 6) @(posedge mclk);
    #1;
  endtask
  // One read cycle, answer checked after the taking edge
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input hit);
    @(posedge mclk);
    #1;
    rd_en = 1'b1;
    rd_addr = a;
    @(posedge mclk);
    #1;
    rd_en = 1'b0;
    chk(rd_hit, hit);
    chk(rd_data, exp);
  endtask
  // Clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Hang limit
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 3000) begin
      miscompares++;
      close_out();
    end
  end
  // Main sequence
  initial begin
    {sys_rst, go, rd_en, rd_addr, delay} = {3'b100, 20'h0};
    {img_sel, img_iface, img_pulse, img_ext} = 40'h0;
    {first_pulse_output, second_pulse_output} = 2'b00;
    repeat (4) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    chk({first_latch_input_is_input, second_latch_input_is_input}, 2'b11);
    rd(16'h0150, 8'h00, 1'b1);
    rd(16'h0153, 8'h00, 1'b1);
    rd(16'h0154, 8'h00, 1'b0);
    rd(16'h014f, 8'h00, 1'b0);
    load(8'h04, 8'h01, 8'h00, 16'ha5c3, 4'h0);
    chk(output_valid_active_low, 1'b1);
    chk(dio_pair_out, 16'ha5c3);
    rd(16'h0152, 8'hc3, 1'b1);
    rd(16'h0153, 8'ha5, 1'b1);
    load(8'h04, 8'h04, 8'h00, 16'ha5c3, 4'h3);
    chk({dio_pair_out, output_valid_active_low}, 17'h0);
    load(8'h80, 8'hff, 8'h00, 16'h3cf0, 4'h1);
    chk({serial_event_fwd_en, ack_active_high, ack_open_drain}, 3'b111);
    chk({spi_pair_od, spi_pair_out}, 16'h3cf0);
    rd(16'h0150, 8'h07, 1'b1);
    load(8'h82, 8'h02, 8'h00, 16'h0000, 4'h2);
    chk({serial_event_fwd_en, ack_active_high, ack_open_drain}, 3'b010);
    for (int m = 0; m < 4; m++) begin
      load(8'h05, (m % 2 ? 8'hfc : 8'hcc) | 8'(m), 8'h00, 16'h0, 4'(m));
      chk({serial_late_sample, serial_chip_select_high, serial_clock_mode},
        {m % 2 == 1, m % 2 == 1, 2'(m)});
      rd(16'h0150, (m % 2 ? 8'h30 : 8'h00) | 8'(m), 1'b1);
    end
    for (int b = 0; b < 2; b++) begin
      load(b ? 8'h97 : 8'h88, b ? 8'haa : 8'h55, 8'h00, 16'hffff, 4'h2);
      chk({bus_ale_qualify, bus_dir_enable, bus_cs_high, bus_rd_sense,
        bus_wr_sense, bus_ale_high, ack_active_high, ack_open_drain},
        b ? 8'haa : 8'h55);
      rd(16'h0152, 8'h07, 1'b1);
      rd(16'h0153, 8'h00, 1'b1);
    end
    for (int c = 0; c < 4; c++) begin
      load(8'h03, 8'hff,
        {c % 2 == 1, 1'b1, 2'(c), c % 2 == 1, 1'b1, 2'(c)}, 16'hffff, 4'h0);
      rd(16'h0151, {c % 2 == 1, 1'b1, 2'(c), c % 2 == 1, 1'b1, 2'(c)},
        1'b1);
      chk({bus_ale_qualify, ack_open_drain, serial_clock_mode}, 4'h0);
      chk({first_latch_input_is_input, second_latch_input_is_input}, 2'b00);
      {first_pulse_output, second_pulse_output} = 2'b11;
      repeat (4) @(posedge mclk);
      #1;
      chk(application_layer_event, {2{c % 2 == 1}});
      chk({pulse0_out, pulse0_oe, pulse1_out, pulse1_oe},
        {2{c / 2 == 1, 1'b1}});
      {first_pulse_output, second_pulse_output} = 2'b00;
      repeat (4) @(posedge mclk);
      #1;
      chk({application_layer_event, pulse0_oe, pulse1_oe},
        {2'b00, {2{c % 2 == 0}}});
      if (c % 2 == 0) chk({pulse0_out, pulse1_out}, {2{c / 2 == 0}});
    end
    close_out();
  end
endmodule
